/* File: verilog/cio_pkg.sv */
// shared constants and types for the configurable io port logic
package cio_pkg;

   // ***************************************************
   // port geometry
   // ***************************************************
   localparam int CIO_NPORT = 4;
   localparam int CIO_PW    = 8;
   localparam int CIO_NIMC  = 3;
   // port d carries only its three low pins
   localparam logic [3:0][7:0] CIO_PORT_MASK =
      {8'h07, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [3:0] CIO_CTRL_PORTS = 4'h3;

   // ***************************************************
   // io_register_space layout: address = {func, port}
   // ***************************************************
   localparam int         CIO_AW      = 5;
   localparam logic [2:0] CIO_F_PIN   = 3'h0;
   localparam logic [2:0] CIO_F_DOUT  = 3'h1;
   localparam logic [2:0] CIO_F_DIR   = 3'h2;
   localparam logic [2:0] CIO_F_CTRL  = 3'h3;
   localparam logic [2:0] CIO_F_CAP   = 3'h4;
   localparam logic [2:0] CIO_F_MCELL = 3'h5;

   // ***************************************************
   // reset values and field positions
   // ***************************************************
   localparam logic [7:0] CIO_REG_RST  = 8'h00;
   localparam int         CIO_PASS_BIT = 7;

   // ***************************************************
   // types
   // ***************************************************
   typedef enum logic [1:0] {
      CIO_BUS_MUX    = 2'h0,
      CIO_BUS_NONMUX = 2'h1,
      CIO_BUS_BURST  = 2'h3,
      CIO_BUS_PAGED  = 2'h2
   } cio_bus_t;

   typedef enum logic [1:0] {
      CIO_CAP_DIRECT = 2'h0,
      CIO_CAP_LATCH  = 2'h1,
      CIO_CAP_REG    = 2'h3
   } cio_cap_t;

   // programmed configuration, fixed at run time
   typedef struct packed {
      cio_bus_t                   bus_type;
      logic                       data_port_a;
      logic [3:0][7:0]            la_out;
      logic [3:0][7:0]            oe_pt_def;
      logic [2:0][7:0][1:0]       cap_mode;
      logic [2:0]                 cap_clk_pt;
      logic                       test_cfg;
   } cio_cfg_t;

   // live terms from the complex_logic_array
   typedef struct packed {
      logic [3:0][7:0]            mcell;
      logic [3:0][7:0]            oe_pt;
      logic [2:0]                 cap_pt_clk;
      logic                       passthrough_select_0;
      logic                       passthrough_select_1;
      logic                       test_port_select_term;
   } cio_la_t;

endpackage

/* File: verilog/cio_port_logic.sv */
// configurable io port logic: four ports, output mux, readback, capture
//
// Behaviour
// - four ports, three of eight pins and one of three, each pin alone
// - pin output muxes data reg, latched address, macrocell, chip select
// - readback returns exactly one selected source per host read
// - driver enable is direction bit OR logic-array enable term
// - without enable term and logic-array output, direction bit decides
// - capture cells: latch, edge register or direct; strobe or term clock
// - programmed modes fixed; control and direction writable at run time
// - writing zero to a mode bit selects host io mode
// - host io: output pins drive data reg, input pins read back
// - third and fourth ports lack mode register, default host io
// - logic-array output tri-stated only with enable term and direction both zero
// - address out only with enable term or direction and mode both one
// - non-multiplexed bus puts A7-A0 only on the second port
// - address nibble mapping follows host bus type
// - mode availability differs per port
// - mode and direction bit encodings select host io or address out
// - test pins enabled by select term, configuration or enable pin
// - memory mode bit 7 makes first port a host data buffer
// - passthrough buffer tri-stated when neither select is active
// - mode, direction registers reset to zero: all inputs, host io
`timescale 1ns/1ps

module cio_port_logic
   import cio_pkg::*;
(
   // clock and reset
   input  wire logic                   I_CLK,
   input  wire logic                   I_RESET_N,
   // host register access
   input  wire logic                   I_WR_STB,
   input  wire logic [CIO_AW-1:0]      I_REG_ADDR,
   input  wire logic [7:0]             I_WR_DATA,
   output logic      [7:0]             O_RD_DATA,
   // host address and data path
   input  wire logic                   I_ADDR_LATCH_STROBE,
   input  wire logic [15:0]            I_ADDR,
   input  wire logic [7:0]             I_MEMORY_MODE_REGISTER,
   input  wire logic                   I_HOST_RD_CYCLE,
   input  wire logic                   I_HOST_ACC,
   input  wire logic [7:0]             I_HOST_DATA,
   output logic      [7:0]             O_HOST_DATA,
   // configuration and logic array
   input  wire cio_cfg_t               I_CFG,
   input  wire cio_la_t                I_LA,
   input  wire logic [2:0]             I_CS_EXT,
   input  wire logic                   I_TEST_ENABLE,
   // pins
   input  wire logic [3:0][7:0]        I_PORT_IN,
   output logic      [3:0][7:0]        O_PORT_OUT,
   output logic      [3:0][7:0]        O_PORT_OE,
   // capture cells and test port
   output logic      [2:0][7:0]        O_CAP,
   output logic                        O_TEST_PORT_EN
);

   // ***************************************************
   // register space decode
   // ***************************************************
   logic [2:0]            acc_func;
   logic [1:0]            acc_port;

   assign acc_func = I_REG_ADDR[4:2];
   assign acc_port = I_REG_ADDR[1:0];

   // ***************************************************
   // host written registers
   // ***************************************************
   logic [3:0][7:0]       dout_r;
   logic [3:0][7:0]       dir_r;
   logic [1:0][7:0]       ctrl_r;

   // data out registers, width trimmed per port
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         dout_r <= {CIO_NPORT{CIO_REG_RST}};
      end else if (I_WR_STB && acc_func == CIO_F_DOUT) begin
         dout_r[acc_port] <= I_WR_DATA &
                             CIO_PORT_MASK[acc_port];
      end
   end

   // direction registers; reset leaves every pin an input
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         dir_r <= {CIO_NPORT{CIO_REG_RST}};
      end else if (I_WR_STB && acc_func == CIO_F_DIR) begin
         dir_r[acc_port] <= I_WR_DATA &
                            CIO_PORT_MASK[acc_port];
      end
   end

   // mode registers exist for the first two ports only
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ctrl_r <= {2{CIO_REG_RST}};
      end else if (I_WR_STB && acc_func == CIO_F_CTRL &&
                   CIO_CTRL_PORTS[acc_port]) begin
         ctrl_r[acc_port[0]] <= I_WR_DATA;
      end
   end

   // ***************************************************
   // address latch
   // ***************************************************
   logic [15:0]           addr_lat_r;
   logic [15:0]           addr_use;

   // loads on each clock edge while the strobe is high, holds after
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         addr_lat_r <= 16'h0000;
      end else if (I_ADDR_LATCH_STROBE) begin
         addr_lat_r <= I_ADDR;
      end
   end

   // a non-multiplexed host holds its address, no latch needed
   assign addr_use = (I_CFG.bus_type == CIO_BUS_NONMUX) ?
                     I_ADDR : addr_lat_r;

   // ***************************************************
   // address nibble mapping per bus type
   // ***************************************************
   logic [1:0][7:0]       addr_byte;
   logic [1:0][7:0]       addr_avail;

   always_comb begin
      addr_byte  = '0;
      addr_avail = '0;
      case (I_CFG.bus_type)
         CIO_BUS_MUX: begin
            addr_byte[0]  = addr_use[7:0];
            addr_byte[1]  = addr_use[7:0];
            addr_avail    = {2{8'hFF}};
         end
         CIO_BUS_NONMUX: begin
            addr_byte[1]  = addr_use[7:0];
            addr_avail[1] = 8'hFF;
         end
         CIO_BUS_BURST: begin
            addr_byte[0]  = {addr_use[7:4], 4'h0};
            addr_avail[0] = 8'hF0;
            addr_byte[1]  = {4'h0, addr_use[11:8]};
            addr_avail[1] = 8'h0F;
         end
         CIO_BUS_PAGED: begin
            addr_byte[1]  = addr_use[15:8];
            addr_avail[1] = 8'hFF;
         end
         default: begin
            addr_byte  = '0;
            addr_avail = '0;
         end
      endcase
   end

   // ***************************************************
   // first port bus modes: data port and passthrough
   // ***************************************************
   logic                  pass_on;
   logic                  bus_mode_a;
   logic                  bus_sel_a;

   assign pass_on    = I_MEMORY_MODE_REGISTER[CIO_PASS_BIT];
   assign bus_mode_a = I_CFG.data_port_a | pass_on;
   // data port follows host access; passthrough follows its selects
   assign bus_sel_a  = I_CFG.data_port_a ? I_HOST_ACC :
                       (I_LA.passthrough_select_0 |
                        I_LA.passthrough_select_1);

   // ***************************************************
   // per port output mux and driver enable
   // ***************************************************
   logic [3:0][7:0]       out_nxt;
   logic [3:0][7:0]       oe_nxt;

   for (genvar p = 0; p < CIO_NPORT; p++) begin : g_port
      logic [7:0] la_src;
      logic [7:0] pt_oe;
      logic [7:0] addr_sel;

      // port d takes extra chip selects instead of macrocells
      if (p == 3) begin : g_cs
         assign la_src = {5'h00, I_CS_EXT};
      end else begin : g_mc
         assign la_src = I_LA.mcell[p];
      end

      // undefined enable terms contribute nothing
      assign pt_oe = I_LA.oe_pt[p] & I_CFG.oe_pt_def[p];

      // address out only where the port has a mode register
      if (p < 2) begin : g_addr
         assign addr_sel = ctrl_r[p] & addr_avail[p];
      end else begin : g_noaddr
         assign addr_sel = 8'h00;
      end

      always_comb begin
         for (int b = 0; b < CIO_PW; b++) begin
            if (I_CFG.la_out[p][b]) begin
               out_nxt[p][b] = la_src[b];
            end else if (addr_sel[b]) begin
               out_nxt[p][b] = addr_byte[p % 2][b];
            end else begin
               out_nxt[p][b] = dout_r[p][b];
            end
            // same or covers host io, address out and array outputs
            oe_nxt[p][b] = dir_r[p][b] |
                           pt_oe[b];
         end
         // passthrough and data port take over the whole first port
         if (p == 0 && bus_mode_a) begin
            out_nxt[p] = I_HOST_DATA;
            oe_nxt[p]  = {8{bus_sel_a & ~I_HOST_RD_CYCLE}};
         end
         out_nxt[p] = out_nxt[p] & CIO_PORT_MASK[p];
         oe_nxt[p]  = oe_nxt[p] & CIO_PORT_MASK[p];
      end
   end

   // pin outputs registered; costs one cycle, keeps pins glitch free
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_PORT_OUT <= '0;
         O_PORT_OE  <= '0;
      end else begin
         O_PORT_OUT <= out_nxt;
         O_PORT_OE  <= oe_nxt;
      end
   end

   // port a read back to the host every cycle, whatever the port mode
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_HOST_DATA <= 8'h00;
      end else begin
         O_HOST_DATA <= I_PORT_IN[0];
      end
   end

   // ***************************************************
   // input_capture_cell array on the three wide ports
   // ***************************************************
   logic [2:0]            cap_clk;
   logic [2:0]            cap_clk_prev_r;
   logic [2:0][7:0]       cap_nxt;

   // clock source per port: strobe or product term
   always_comb begin
      for (int p = 0; p < CIO_NIMC; p++) begin
         cap_clk[p] = I_CFG.cap_clk_pt[p] ? I_LA.cap_pt_clk[p] :
                      I_ADDR_LATCH_STROBE;
      end
   end

   // previous clock level gives the rising edge
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         cap_clk_prev_r <= 3'h0;
      end else begin
         cap_clk_prev_r <= cap_clk;
      end
   end

   // per bit capture mode; an unused code simply holds
   always_comb begin
      cap_nxt = O_CAP;
      for (int p = 0; p < CIO_NIMC; p++) begin
         for (int b = 0; b < CIO_PW; b++) begin
            case (cio_cap_t'(I_CFG.cap_mode[p][b]))
               CIO_CAP_DIRECT: begin
                  cap_nxt[p][b] = I_PORT_IN[p][b];
               end
               CIO_CAP_LATCH: begin
                  if (cap_clk[p]) begin
                     cap_nxt[p][b] = I_PORT_IN[p][b];
                  end
               end
               CIO_CAP_REG: begin
                  if (cap_clk[p] && !cap_clk_prev_r[p]) begin
                     cap_nxt[p][b] = I_PORT_IN[p][b];
                  end
               end
               default: begin
                  cap_nxt[p][b] = O_CAP[p][b];
               end
            endcase
         end
      end
   end

   // capture state feeds the array and the readback
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CAP <= '0;
      end else begin
         O_CAP <= cap_nxt;
      end
   end

   // ***************************************************
   // port_readback_buffer: one source per read
   // ***************************************************
   logic [7:0]            rd_nxt;

   always_comb begin
      case (acc_func)
         CIO_F_PIN:   rd_nxt = I_PORT_IN[acc_port];
         CIO_F_DOUT:  rd_nxt = dout_r[acc_port];
         CIO_F_DIR:   rd_nxt = dir_r[acc_port];
         CIO_F_CTRL: begin
            rd_nxt = CIO_CTRL_PORTS[acc_port] ?
                     ctrl_r[acc_port[0]] : 8'h00;
         end
         CIO_F_CAP: begin
            rd_nxt = (acc_port == 2'h3) ? 8'h00 : O_CAP[acc_port];
         end
         CIO_F_MCELL: rd_nxt = I_LA.mcell[acc_port];
         default:     rd_nxt = 8'h00;
      endcase
      rd_nxt = rd_nxt & CIO_PORT_MASK[acc_port];
   end

   // readback tracks the address; host samples one cycle later
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RD_DATA <= 8'h00;
      end else begin
         O_RD_DATA <= rd_nxt;
      end
   end

   // ***************************************************
   // serial test port enable on the third port
   // ***************************************************
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_TEST_PORT_EN <= 1'b0;
      end else begin
         O_TEST_PORT_EN <= I_LA.test_port_select_term |
                           I_CFG.test_cfg |
                           I_TEST_ENABLE;
      end
   end

endmodule // cio_port_logic

/* File: testbench/cio_port_logic_assertions.sv */
// concurrent checks on the ports of the configurable io port logic
`timescale 1ns/1ps

module cio_port_logic_assertions
   import cio_pkg::*;
(
   // clock and reset
   input wire logic              I_CLK,
   input wire logic              I_RESET_N,
   // host side
   input wire logic [CIO_AW-1:0] I_REG_ADDR,
   input wire logic [7:0]        O_RD_DATA,
   input wire logic [7:0]        I_MEMORY_MODE_REGISTER,
   input wire logic              I_HOST_RD_CYCLE,
   input wire logic [7:0]        I_HOST_DATA,
   // configuration, terms and pins
   input wire cio_cfg_t          I_CFG,
   input wire cio_la_t           I_LA,
   input wire logic              I_TEST_ENABLE,
   input wire logic [3:0][7:0]   I_PORT_IN,
   input wire logic [3:0][7:0]   O_PORT_OUT,
   input wire logic [3:0][7:0]   O_PORT_OE,
   input wire logic [2:0][7:0]   O_CAP,
   input wire logic              O_TEST_PORT_EN
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   // enable terms of ports b to d; port a may be in bus mode
   wire logic [2:0][7:0] oe_term = I_LA.oe_pt[3:1] & I_CFG.oe_pt_def[3:1]
                                   & CIO_PORT_MASK[3:1];

   // ****************************************
   // properties
   // ****************************************
   a_rd_unused_func: assert property (I_REG_ADDR[4:3] == 2'h3
      |=> O_RD_DATA == 8'h00) else $error("unused func read not zero");
   a_ctrl_cd_zero: assert property (I_REG_ADDR[4:1] == 4'h7
      |=> O_RD_DATA == 8'h00) else $error("ctrl of port c or d not zero");
   a_pin_readback: assert property (I_REG_ADDR == 5'h02
      |=> O_RD_DATA == $past(I_PORT_IN[2])) else $error("pin readback");
   a_port_d_narrow: assert property (
      (O_PORT_OUT[3][7:3] | O_PORT_OE[3][7:3]) == 5'h00)
      else $error("port d upper pins active");
   a_oe_term_on: assert property ($past(I_RESET_N) |->
      (O_PORT_OE[3:1] & $past(oe_term)) == $past(oe_term))
      else $error("enable term did not drive pin");
   a_pass_tristate: assert property (I_MEMORY_MODE_REGISTER[7]
      && !I_LA.passthrough_select_0 && !I_LA.passthrough_select_1
      |=> O_PORT_OE[0] == 8'h00) else $error("passthrough not released");
   a_pass_drive: assert property (I_MEMORY_MODE_REGISTER[7]
      && I_LA.passthrough_select_0 && !I_HOST_RD_CYCLE
      |=> O_PORT_OE[0] == 8'hFF && O_PORT_OUT[0] == $past(I_HOST_DATA))
      else $error("passthrough write path wrong");
   a_test_on: assert property (I_TEST_ENABLE |=> O_TEST_PORT_EN)
      else $error("test pins not enabled");
   a_test_off: assert property (!(I_TEST_ENABLE || I_CFG.test_cfg
      || I_LA.test_port_select_term) |=> !O_TEST_PORT_EN)
      else $error("test pins enabled unasked");
   a_cap_direct: assert property (I_CFG.cap_mode[1][0] == 2'h0
      |=> O_CAP[1][0] == $past(I_PORT_IN[1][0]))
      else $error("direct capture cell lags");
endmodule // cio_port_logic_assertions

bind cio_port_logic cio_port_logic_assertions u_chk (
   .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_REG_ADDR(I_REG_ADDR),
   .O_RD_DATA(O_RD_DATA), .I_MEMORY_MODE_REGISTER(I_MEMORY_MODE_REGISTER),
   .I_HOST_RD_CYCLE(I_HOST_RD_CYCLE), .I_HOST_DATA(I_HOST_DATA),
   .I_CFG(I_CFG), .I_LA(I_LA), .I_TEST_ENABLE(I_TEST_ENABLE),
   .I_PORT_IN(I_PORT_IN), .O_PORT_OUT(O_PORT_OUT), .O_PORT_OE(O_PORT_OE),
   .O_CAP(O_CAP), .O_TEST_PORT_EN(O_TEST_PORT_EN));

/* File: testbench/cio_pin_model.sv */
// pad model: resolves each pin from driver enable and outside source
`timescale 1ns/1ps

module cio_pin_model
   import cio_pkg::*;
(
   // clock
   input  wire logic            i_clk,
   // drive from the port logic and from outside
   input  wire logic [3:0][7:0] i_out,
   input  wire logic [3:0][7:0] i_oe,
   input  wire logic [3:0][7:0] i_ext,
   input  wire logic            i_ext_en,
   // level seen by the port logic
   output logic      [3:0][7:0] o_pin
);
   // known start, else a floating pad stays unknown for ever
   logic [3:0][7:0] last_r = '0;
   // floating pads flip each cycle so a stale level never passes
   always_ff @(posedge i_clk) begin
      last_r <= o_pin;
   end
   // enabled pads win; outside drive only where the pin is an input
   assign o_pin = (i_out & i_oe)
                | (~i_oe & (i_ext_en ? i_ext : ~last_r));
endmodule // cio_pin_model

/* File: testbench/testbench.sv */
// self-checking bench for the configurable io port logic
`timescale 1ns/1ps

module testbench
   import cio_pkg::*;
;
   logic            clk, rst_n, stb, strb, rdc, acc, ten, tpe, ext_en;
   logic [4:0]      addr;
   logic [7:0]      wd, rdd, mmr, hd, hdo, d, r, v;
   logic [15:0]     adr, seed;
   logic [2:0]      cs;
   cio_cfg_t        cfg;
   cio_la_t         la;
   logic [3:0][7:0] pin, pout, poe, ext;
   logic [2:0][7:0] cap;
   int              err_count = 0;
   int              checks_done = 0;

   cio_port_logic uut (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_WR_STB(stb), .I_REG_ADDR(addr),
      .I_WR_DATA(wd), .O_RD_DATA(rdd), .I_ADDR_LATCH_STROBE(strb),
      .I_ADDR(adr), .I_MEMORY_MODE_REGISTER(mmr), .I_HOST_RD_CYCLE(rdc),
      .I_HOST_ACC(acc), .I_HOST_DATA(hd), .O_HOST_DATA(hdo), .I_CFG(cfg),
      .I_LA(la), .I_CS_EXT(cs), .I_TEST_ENABLE(ten), .I_PORT_IN(pin),
      .O_PORT_OUT(pout), .O_PORT_OE(poe), .O_CAP(cap),
      .O_TEST_PORT_EN(tpe));
   cio_pin_model u_pins (.i_clk(clk), .i_out(pout), .i_oe(poe),
      .i_ext(ext), .i_ext_en(ext_en), .o_pin(pin));

   // ****************************************
   // helpers
   // ****************************************
   // 16-bit lfsr, fixed start for a repeatable run
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   // address nibbles per host bus; unmapped nibbles keep the data reg
   function automatic logic [7:0] exp_addr(cio_bus_t t, int p,
                                           logic [15:0] a, logic [7:0] o);
      case (t)
         CIO_BUS_MUX:    return a[7:0];
         CIO_BUS_NONMUX: return p ? a[7:0] : o;
         CIO_BUS_BURST:  return p ? {o[7:4], a[11:8]} : {a[7:4], o[3:0]};
         default:        return p ? a[15:8] : o;
      endcase
   endfunction
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] dat);
      @(negedge clk);
      addr = a;
      wd = dat;
      stb = 1'b1;
      @(negedge clk);
      stb = 1'b0;
   endtask
   task automatic rdchk(string n, logic [4:0] a, logic [7:0] e);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      chk(n, e, rdd);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************
   // clock, watchdog and tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // the tests take well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end
   initial begin
      {stb, strb, rdc, acc, ten, ext_en, rst_n} = '0;
      {addr, wd, mmr, hd, adr, cs, ext} = '0;
      cfg = '0;
      la = '0;
      seed = 16'h002E;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      for (int p = 0; p < 4; p++) begin
         chk("oe", 8'h00, poe[p]);
         rdchk("dir", {CIO_F_DIR, p[1:0]}, 8'h00);
         rdchk("ctrl", {CIO_F_CTRL, p[1:0]}, 8'h00);
      end
      rdchk("unused", 5'h18, 8'h00);
      $display("test reset done");
      ext_en = 1'b1;
      for (int p = 0; p < 4; p++) begin
         d = rnd();
         r = rnd();
         ext[p] = rnd();
         wr({CIO_F_DOUT, p[1:0]}, d);
         wr({CIO_F_DIR, p[1:0]}, r);
         wr({CIO_F_CTRL, p[1:0]}, 8'hFF);
         wr({CIO_F_CTRL, p[1:0]}, 8'h00);
         @(negedge clk);
         chk("oe", r & CIO_PORT_MASK[p], poe[p]);
         chk("out", d & r & CIO_PORT_MASK[p], pout[p] & r);
         rdchk("dat", {CIO_F_DOUT, p[1:0]}, d & CIO_PORT_MASK[p]);
         rdchk("dir", {CIO_F_DIR, p[1:0]}, r & CIO_PORT_MASK[p]);
         v = ((d & r) | (ext[p] & ~r)) & CIO_PORT_MASK[p];
         rdchk("pin", {CIO_F_PIN, p[1:0]}, v);
      end
      $display("test host io done");
      adr = {rnd(), rnd()};
      strb = 1'b1;
      @(negedge clk);
      strb = 1'b0;
      for (int i = 0; i < 4; i++) begin
         cfg.bus_type = cio_bus_t'(i);
         for (int p = 0; p < 2; p++) begin
            d = rnd();
            wr({CIO_F_DOUT, p[1:0]}, d);
            wr({CIO_F_DIR, p[1:0]}, 8'hFF);
            wr({CIO_F_CTRL, p[1:0]}, 8'hFF);
            @(negedge clk);
            v = exp_addr(cfg.bus_type, p, adr, d);
            chk("addr", v, pout[p]);
            chk("addr oe", 8'hFF, poe[p]);
            wr({CIO_F_CTRL, p[1:0]}, 8'h00);
            @(negedge clk);
            chk("back", d, pout[p]);
         end
      end
      $display("test address out done");
      cfg.la_out[2] = 8'hFF;
      la.mcell[2] = rnd();
      wr({CIO_F_DIR, 2'h2}, 8'hFF);
      @(negedge clk);
      chk("mcell", la.mcell[2], pout[2]);
      rdchk("mcell rd", {CIO_F_MCELL, 2'h2}, la.mcell[2]);
      wr({CIO_F_DIR, 2'h2}, 8'h00);
      la.oe_pt[2] = rnd();
      @(negedge clk);
      chk("la off", 8'h00, poe[2]);
      cfg.oe_pt_def[2] = 8'hFF;
      @(negedge clk);
      chk("la oe", la.oe_pt[2], poe[2]);
      $display("test logic array done");
      mmr = 8'h80;
      hd = rnd();
      la.passthrough_select_0 = 1'b1;
      @(negedge clk);
      chk("pass out", hd, pout[0]);
      {rdc, la.passthrough_select_0} = 2'h3;
      @(negedge clk);
      @(negedge clk);
      chk("pass in", ext[0], hdo);
      {rdc, la.passthrough_select_0} = 2'h0;
      @(negedge clk);
      chk("pass off", 8'h00, poe[0]);
      la.passthrough_select_1 = 1'b1;
      @(negedge clk);
      chk("pass sel1", 8'hFF, poe[0]);
      {mmr, rdc, la.passthrough_select_1} = '0;
      cfg.data_port_a = 1'b1;
      acc = 1'b1;
      hd = rnd();
      @(negedge clk);
      chk("dport out", hd, pout[0]);
      chk("dport oe", 8'hFF, poe[0]);
      {cfg.data_port_a, acc} = '0;
      cfg.la_out[3] = 8'h07;
      r = rnd();
      cs = r[2:0];
      @(negedge clk);
      chk("cs out", {5'h00, cs}, pout[3]);
      for (int m = 0; m < 4; m++) begin
         ten = (m == 1);
         cfg.test_cfg = (m == 2);
         la.test_port_select_term = (m == 3);
         @(negedge clk);
         chk("test en", {7'h00, m != 0}, {7'h00, tpe});
      end
      $display("test passthrough and test pins done");
      wr({CIO_F_DIR, 2'h1}, 8'h00);
      ext[1] = rnd();
      @(negedge clk);
      rdchk("cap", {CIO_F_CAP, 2'h1}, ext[1]);
      cfg.cap_mode[1] = {8{CIO_CAP_REG}};
      v = ext[1];
      strb = 1'b1;
      repeat (2) @(negedge clk);
      strb = 1'b0;
      repeat (2) @(negedge clk);
      ext[1] = ~v;
      repeat (2) @(negedge clk);
      chk("cap reg", v, cap[1]);
      // latch clocked by the product term, strobe left low
      cfg.cap_mode[1] = {8{CIO_CAP_LATCH}};
      cfg.cap_clk_pt[1] = 1'b1;
      la.cap_pt_clk[1] = 1'b1;
      repeat (2) @(negedge clk);
      chk("cap latch", ext[1], cap[1]);
      la.cap_pt_clk[1] = 1'b0;
      ext[1] = v;
      repeat (2) @(negedge clk);
      chk("cap hold", ~v, cap[1]);
      $display("test capture done");
      close_out();
   end
endmodule // testbench
